// File: bench/cpps_monitor.sv
// Port checker for the preset parameter store.
`timescale 1ns/1ns
`default_nettype none
module cpps_monitor (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // Register bus handshakes.
  input wire logic S_AXI_AWVALID_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // Frame timing and live parameters.
  input wire logic FRAME_START_IN,
  input wire logic [31:0] EXPOSURE_DURATION_OUT,
  input wire logic [15:0] ANALOG_AMP_OUT,
  input wire logic [15:0] DIGITAL_AMP_OUT,
  input wire logic [15:0] ROI_ORIGIN_H_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Cycles since a frame start or a write; saturates so it never wraps.
  logic [3:0] quiet_reg;
  // Live values may only move shortly after one of those two causes.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || FRAME_START_IN ||
        (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)) begin
      quiet_reg <= 4'h0;
    end else if (quiet_reg != 4'hF) begin
      quiet_reg <= quiet_reg + 4'h1;
    end
  end
  gain_range_a: assert property (ANALOG_AMP_OUT <= 16'h8000)
    else $error("analog part above half range");
  gain_split_a: assert property (DIGITAL_AMP_OUT != 16'h0000 |->
    ANALOG_AMP_OUT == 16'h8000) else $error("digital part without full analog");
  roi_frame_a: assert property ($changed(ROI_ORIGIN_H_OUT) |->
    quiet_reg < 4'h8) else $error("origin moved mid frame");
  exp_frame_a: assert property ($changed(EXPOSURE_DURATION_OUT) |->
    quiet_reg < 4'h8) else $error("exposure moved mid frame");
  write_resp_a: assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT
    |-> ##[1:6] S_AXI_BVALID_OUT) else $error("write response missing");
  bresp_ok_a: assert property (S_AXI_BVALID_OUT |->
    S_AXI_BRESP_OUT == 2'h0) else $error("write response not okay");
  bvalid_once_a: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN
    |=> !S_AXI_BVALID_OUT) else $error("write response repeated");
  read_same_a: assert property (S_AXI_ARREADY_OUT |->
    S_AXI_RVALID_OUT) else $error("read data not with address accept");
  rvalid_once_a: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN
    |=> !S_AXI_RVALID_OUT) else $error("read data repeated");
endmodule : cpps_monitor
bind cpps_store cpps_monitor mon (.*);
`default_nettype wire

// File: bench/cycling_preset_parameter_set_tb_top.sv
// Self-checking bench for the preset parameter store.
`timescale 1ns/1ns
`default_nettype none
`include "cpps_regs.svh"
module cycling_preset_parameter_set_tb_top import cpps_pkg::*;;
  // Stimulus, all idle at time zero.
  logic clk;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, arv = 1'b0, fs = 1'b0, es = 1'b0, ea = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] aidx = 4'h0;
  // Observed outputs.
  logic awr, wr_o, bv, arr, rv, cgv_o;
  logic [1:0] br, rr;
  logic [31:0] rd_o, exp_o, dly_o, max_o;
  logic [15:0] an_o, dg_o, rh_o, rv_o;
  logic [47:0] cg_o;
  logic [7:0] mh_o, mv_o;
  logic [2:0] pin_o;
  int n_mismatch = 0;
  int compares = 0;
  // Strobes and ready lines are tied: every write is full word.
  cpps_store dut (.CLK_IN(clk), .RST_N_IN(rst_n),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wr_o), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(1'b1), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rd_o), .S_AXI_RRESP_OUT(rr),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(1'b1), .ACTIVE_INDEX_IN(aidx),
    .FRAME_START_IN(fs), .EXP_START_IN(es), .EXP_ACTIVE_IN(ea),
    .EXPOSURE_DURATION_OUT(exp_o), .EXPOSURE_LEAD_DELAY_OUT(dly_o),
    .MAX_EXPOSURE_DURATION_OUT(max_o), .ANALOG_AMP_OUT(an_o),
    .DIGITAL_AMP_OUT(dg_o), .ROI_ORIGIN_H_OUT(rh_o), .ROI_ORIGIN_V_OUT(rv_o),
    .COLOUR_GAIN_OUT(cg_o), .COLOUR_GAIN_VALID_OUT(cgv_o),
    .MERGE_H_OUT(mh_o), .MERGE_V_OUT(mv_o), .OUTPUT_PIN_OUT(pin_o));
  // Free running clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // Case-equal compare so an unknown never matches.
  task automatic chk(input logic [47:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // A wait that used its bound ends the run as a failure.
  task automatic guard(input int n);
    if (n >= 40) begin
      n_mismatch++;
      $display("[ERR] %0t bus wait ran out", $time);
      conclude();
    end
  endtask : guard
  // Write: address and data offered together, each released when taken.
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_o) wv <= 1'b0;
    end while (!bv && n < 40);
    @(posedge clk);
    guard(n);
  endtask : bus_wr
  // Read: address held until the data beat is sampled.
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!rv && n < 40);
    d = rd_o;
    r = rr;
    arv <= 1'b0;
    @(posedge clk);
    guard(n);
  endtask : bus_rd
  // Presents an index and a one-cycle frame start, then lets it settle.
  task automatic frame(input logic [3:0] i);
    aidx <= i;
    @(posedge clk);
    fs <= 1'b1;
    @(posedge clk);
    fs <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : frame
  // Packs one pin setting word.
  function automatic logic [31:0] pcfg(logic lv, cpps_src_t o, logic [1:0] k);
    return {27'h000_0000, lv, o, k};
  endfunction : pcfg
  // Reset values and an unmapped read.
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    chk(exp_o, 48'h0, "exposure after reset");
    chk(pin_o, 48'h0, "pins after reset");
    bus_rd(`CPPS_OFF_MERGE, d, r);
    chk(d, {`CPPS_RST_MERGE, `CPPS_RST_MERGE}, "merge reset");
    bus_rd(12'h0FC, d, r);
    chk({r, d}, {2'h2, 32'h0000_0000}, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  // Two presets; the live one changes only at a frame start.
  task automatic t_preset();
    logic [31:0] d, s;
    logic [1:0] r;
    bus_wr(`CPPS_OFF_CONTROL, 32'h0000_0008);
    for (int p = 2; p <= 5; p += 3) begin
      bus_wr(`CPPS_OFF_INDEX, p);
      bus_wr(`CPPS_OFF_EXPOSURE, 32'h0000_1000 * p);
      bus_wr(`CPPS_OFF_LEAD_DELAY, 32'h0000_0010 + p);
      bus_wr(`CPPS_OFF_ROI, 32'h0030_0040 + 32'h0001_0001 * p);
      bus_wr(`CPPS_OFF_MERGE, 32'h0000_0200 + p);
    end
    frame(4'h2);
    chk({exp_o, rh_o}, {32'h0000_2000, 16'h0042}, "preset two");
    chk({dly_o, rv_o}, {32'h0000_0012, 16'h0032}, "preset two");
    chk({mh_o, mv_o}, 48'h0202, "merge two");
    chk(max_o, 48'h5000, "longest exposure");
    aidx <= 4'h5;
    repeat (4) @(posedge clk);
    chk({exp_o, rh_o}, {32'h0000_2000, 16'h0042}, "mid frame");
    frame(4'h5);
    chk({exp_o, rh_o}, {32'h0000_5000, 16'h0045}, "preset five");
    chk({dly_o, rv_o}, {32'h0000_0015, 16'h0035}, "preset five");
    chk({mh_o, mv_o}, 48'h0502, "merge five");
    bus_rd(`CPPS_OFF_STD_EXPOSURE, s, r);
    bus_wr(`CPPS_OFF_STD_EXPOSURE, s ^ 32'h0000_0777);
    bus_rd(`CPPS_OFF_STD_EXPOSURE, d, r);
    chk(d, s, "standard exposure locked");
    $display("test preset done");
  endtask : t_preset
  // Amplification split and its restriction to the live preset.
  task automatic t_gain();
    logic [15:0] g[3] = '{16'h7FFF, 16'h8000, 16'hFFFF};
    foreach (g[i]) begin
      bus_wr(`CPPS_OFF_AMP, {16'h0000, g[i]});
      repeat (4) @(posedge clk);
      chk(an_o, g[i] < 16'h8000 ? g[i] : 16'h8000, "analog");
      chk(dg_o, g[i] < 16'h8000 ? 16'h0 : g[i] - 16'h8000, "digital");
    end
    bus_wr(`CPPS_OFF_INDEX, 32'h0000_0002);
    bus_wr(`CPPS_OFF_AMP, 32'h0000_0100);
    repeat (4) @(posedge clk);
    chk({an_o, dg_o}, 48'h8000_7FFF, "idle preset amp");
    bus_wr(`CPPS_OFF_INDEX, 32'h0000_0005);
    $display("test gain done");
  endtask : t_gain
  // Colour components by selector, valid only with both autos off.
  task automatic t_colour();
    logic [31:0] d;
    logic [1:0] r;
    for (int c = 0; c < 3; c++) begin
      bus_wr(`CPPS_OFF_COLOUR_SEL, c);
      bus_wr(`CPPS_OFF_COLOUR_GAIN, 32'h0000_0011 * (c + 1));
    end
    bus_wr(`CPPS_OFF_COLOUR_SEL, 32'h0000_0001);
    bus_rd(`CPPS_OFF_COLOUR_GAIN, d, r);
    chk(d, 48'h22, "green read back");
    chk({cgv_o, cg_o}, {1'b1, 48'h0033_0022_0011}, "colour live");
    for (int m = 9; m <= 10; m++) begin
      bus_wr(`CPPS_OFF_CONTROL, m);
      repeat (4) @(posedge clk);
      chk(cgv_o, 48'h0, "auto mode on");
    end
    bus_wr(`CPPS_OFF_CONTROL, 32'h0000_0008);
    $display("test colour done");
  endtask : t_colour
  // Every pin and origin, then the held level and its apply command.
  task automatic t_pins();
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 3; k++) begin
      bus_wr(`CPPS_OFF_PIN, pcfg(1'b1, CPPS_SRC_HOST, 2'(k)));
      repeat (4) @(posedge clk);
      chk(pin_o[k], 48'h1, "host level closes");
      bus_wr(`CPPS_OFF_PIN, pcfg(1'b1, CPPS_SRC_OFF, 2'(k)));
      repeat (4) @(posedge clk);
      chk(pin_o[k], 48'h0, "origin off");
    end
    bus_wr(`CPPS_OFF_PIN, pcfg(1'b0, CPPS_SRC_WINDOW, 2'h0));
    ea <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pin_o[0], 48'h1, "window open");
    ea <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pin_o[0], 48'h0, "window shut");
    bus_wr(`CPPS_OFF_PIN, pcfg(1'b0, CPPS_SRC_BEGIN_PULSE, 2'h1));
    es <= 1'b1;
    @(posedge clk);
    es <= 1'b0;
    repeat (`CPPS_PULSE_CYC - 4) @(posedge clk);
    chk(pin_o[1], 48'h1, "pulse held");
    repeat (8) @(posedge clk);
    chk(pin_o[1], 48'h0, "pulse ended");
    bus_wr(`CPPS_OFF_CONTROL, 32'h0000_000C);
    bus_wr(`CPPS_OFF_PIN, pcfg(1'b1, CPPS_SRC_HOST, 2'h2));
    repeat (4) @(posedge clk);
    chk(pin_o[2], 48'h0, "level pending");
    bus_wr(`CPPS_OFF_COMMAND, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk(pin_o[2], 48'h1, "level applied");
    bus_rd(`CPPS_OFF_PIN, d, r);
    chk(d, pcfg(1'b1, CPPS_SRC_HOST, 2'h2), "pin read back");
    $display("test pins done");
  endtask : t_pins
  // Main sequence: two reset cycles, then each scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_preset();
    t_gain();
    t_colour();
    t_pins();
    conclude();
  end
endmodule : cycling_preset_parameter_set_tb_top
`default_nettype wire

// File: pkg/cpps_pin_if.sv
// Carrier between the store and one output pin driver.
`timescale 1ns/1ns
`default_nettype none
interface cpps_pin_if;
  logic [1:0] origin; // Selected source of the pin.
  logic level; // Level to show in host-driven mode.
  logic pin; // Resulting circuit state, high is closed.
  modport store (output origin, output level, input pin);
  modport drv (input origin, input level, output pin);
endinterface : cpps_pin_if
`default_nettype wire

// File: pkg/cpps_pkg.sv
// Types shared by the preset parameter store.
package cpps_pkg;
  // Output pin origin codes.
  typedef enum logic [1:0] {
    CPPS_SRC_OFF = 2'h0,
    CPPS_SRC_HOST = 2'h1,
    CPPS_SRC_BEGIN_PULSE = 2'h2,
    CPPS_SRC_WINDOW = 2'h3
  } cpps_src_t;
  // Bus write states, one-hot.
  typedef enum logic [2:0] {
    CPPS_W_IDLE = 3'b001,
    CPPS_W_DO = 3'b010,
    CPPS_W_RESP = 3'b100
  } cpps_wst_t;
endpackage : cpps_pkg

// File: pkg/cpps_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Summary of operation
// - Per-preset exposure duration in microseconds, used when active.
// - Frame period floor from longest programmed exposure.
// - Per-preset exposure lead delay, used when active.
// - Gain lower half analog, upper half digital.
// - Preset amplification applied only while preset active.
// - Per-preset ROI origin offsets, used when active.
// - Per-preset colour gains; selector picks component accessed.
// - Colour gains only when auto balance, brightness off.
// - Per-preset horizontal cell merge count.
// - Per-preset vertical cell merge count.
// - Per-preset output pin choice among three pins.
// - Host-driven origin drives pin from level setting.
// - Exposure-begin origin pulses at each exposure start.
// - Exposure-window origin asserted exactly during exposure.
// - Direct level apply only host-driven, latching off.
// - Latching holds level pending until apply command.
// - Active level closes circuit; inactive opens it.
// - Cycling enable makes standard setting read-only.
// - Config index selects preset for accesses.
`ifndef CPPS_REGS_SVH
`define CPPS_REGS_SVH
`define CPPS_OFF_INDEX 12'h000
`define CPPS_OFF_EXPOSURE 12'h004
`define CPPS_OFF_LEAD_DELAY 12'h008
`define CPPS_OFF_AMP 12'h00C
`define CPPS_OFF_ROI 12'h010
`define CPPS_OFF_COLOUR_SEL 12'h014
`define CPPS_OFF_COLOUR_GAIN 12'h018
`define CPPS_OFF_MERGE 12'h01C
`define CPPS_OFF_PIN 12'h020
`define CPPS_OFF_CONTROL 12'h024
`define CPPS_OFF_COMMAND 12'h028
`define CPPS_OFF_STATUS 12'h02C
`define CPPS_OFF_STD_EXPOSURE 12'h030
`define CPPS_CTL_AUTO_BAL 0
`define CPPS_CTL_AUTO_BRT 1
`define CPPS_CTL_LATCH 2
`define CPPS_CTL_CYCLE_EN 3
`define CPPS_PIN_LEVEL 4
`define CPPS_CMD_APPLY 0
`define CPPS_RST_MERGE 8'h01
`define CPPS_RST_GAIN 16'h0100
`define CPPS_PULSE_NS 1000
`define CPPS_PULSE_CYC ((`CPPS_PULSE_NS + 9) / 10)
`endif

// File: rtl/cpps_pin_drv.sv
// One output pin driver choosing its source.
`timescale 1ns/1ns
`default_nettype none
`include "cpps_regs.svh"
module cpps_pin_drv
  import cpps_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Exposure events.
  input wire logic exp_start_in,
  input wire logic exp_active_in,
  // Settings and result.
  cpps_pin_if.drv p
);
  logic [15:0] pulse_cnt_reg; // Remaining pulse cycles.
  // Pulse stretcher restarts on every exposure start.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pulse_cnt_reg <= 16'h0000;
    end else if (exp_start_in) begin
      pulse_cnt_reg <= 16'(`CPPS_PULSE_CYC);
    end else if (pulse_cnt_reg != 16'h0000) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end
  end
  // Circuit is closed while the chosen source is active.
  always_comb begin
    case (cpps_src_t'(p.origin))
      CPPS_SRC_OFF: p.pin = 1'b0;
      CPPS_SRC_HOST: p.pin = p.level;
      CPPS_SRC_BEGIN_PULSE: p.pin = (pulse_cnt_reg != 16'h0000);
      CPPS_SRC_WINDOW: p.pin = exp_active_in;
      default: p.pin = 1'b0;
    endcase
  end
endmodule : cpps_pin_drv
`default_nettype wire

// File: rtl/cpps_store.sv
// Per-preset parameter store with AXI4-Lite registers and pin control.
`timescale 1ns/1ns
`default_nettype none
`include "cpps_regs.svh"
module cpps_store
  import cpps_pkg::*;
#(
  parameter int PRESETS = 16, // Number of preset sets.
  parameter int IW = 4 // Width of a preset index.
) (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // AXI4-Lite write address and data.
  input wire logic [11:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  // AXI4-Lite write response.
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // AXI4-Lite read.
  input wire logic [11:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // Cycling unit and timing engine.
  input wire logic [IW-1:0] ACTIVE_INDEX_IN,
  input wire logic FRAME_START_IN,
  input wire logic EXP_START_IN,
  input wire logic EXP_ACTIVE_IN,
  // Parameters of the active preset, and the longest exposure over all presets.
  output logic [31:0] EXPOSURE_DURATION_OUT,
  output logic [31:0] EXPOSURE_LEAD_DELAY_OUT,
  output logic [31:0] MAX_EXPOSURE_DURATION_OUT,
  output logic [15:0] ANALOG_AMP_OUT,
  output logic [15:0] DIGITAL_AMP_OUT,
  output logic [15:0] ROI_ORIGIN_H_OUT,
  output logic [15:0] ROI_ORIGIN_V_OUT,
  output logic [47:0] COLOUR_GAIN_OUT,
  output logic COLOUR_GAIN_VALID_OUT,
  output logic [7:0] MERGE_H_OUT,
  output logic [7:0] MERGE_V_OUT,
  // Output pins, high closes the circuit.
  output logic [2:0] OUTPUT_PIN_OUT
);
  // Per-preset memories.
  logic [31:0] exp_mem [PRESETS]; // Exposure duration in microseconds.
  logic [31:0] dly_mem [PRESETS]; // Lead delay in microseconds.
  logic [15:0] amp_mem [PRESETS]; // Whole-image amplification.
  logic [31:0] roi_mem [PRESETS]; // Vertical high, horizontal low.
  logic [47:0] col_mem [PRESETS]; // Blue, green, red gains.
  logic [15:0] mrg_mem [PRESETS]; // Vertical high, horizontal low.
  logic [4:0] pin_mem [PRESETS]; // Level, origin, pin choice.
  // Control registers.
  logic [IW-1:0] cfg_idx_reg; // Preset addressed by software.
  logic [1:0] col_sel_reg; // Colour component choice.
  logic [3:0] ctl_reg; // Latch, auto modes, cycling enable.
  logic [31:0] std_exp_reg; // Non-cycling exposure setting.
  logic [IW-1:0] live_idx_reg; // Preset in use for this frame.
  logic [2:0] held_reg; // Latched pin levels.
  // Bus state.
  cpps_wst_t wst_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic aw_got_reg;
  logic w_got_reg;
  logic [31:0] wmask;
  logic wr_do;
  logic [IW-1:0] ci;
  logic [31:0] max_w; // Largest exposure over all presets.
  // Pin driver carriers.
  cpps_pin_if pif[3] ();
  logic [2:0] pin_w;

  assign ci = cfg_idx_reg;
  assign wr_do = (wst_reg == CPPS_W_DO);
  // Byte strobes expand into a bit mask.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wstrb_reg[b]}};
    end
  end

  // Write channel: address and data taken in either order.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wst_reg <= CPPS_W_IDLE;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT <= 2'h0;
    end else begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT <= 1'b0;
      case (wst_reg)
        CPPS_W_IDLE: begin
          // Ready pulses once per channel when its item is seen.
          if (S_AXI_AWVALID_IN && !aw_got_reg && !S_AXI_AWREADY_OUT) begin
            S_AXI_AWREADY_OUT <= 1'b1;
            awaddr_reg <= S_AXI_AWADDR_IN;
            aw_got_reg <= 1'b1;
          end
          if (S_AXI_WVALID_IN && !w_got_reg && !S_AXI_WREADY_OUT) begin
            S_AXI_WREADY_OUT <= 1'b1;
            wdata_reg <= S_AXI_WDATA_IN;
            wstrb_reg <= S_AXI_WSTRB_IN;
            w_got_reg <= 1'b1;
          end
          if (aw_got_reg && w_got_reg) begin
            wst_reg <= CPPS_W_DO;
          end
        end
        CPPS_W_DO: begin
          // Register update happens this cycle; respond next.
          S_AXI_BVALID_OUT <= 1'b1;
          S_AXI_BRESP_OUT <= 2'h0;
          wst_reg <= CPPS_W_RESP;
        end
        CPPS_W_RESP: begin
          if (S_AXI_BREADY_IN) begin
            S_AXI_BVALID_OUT <= 1'b0;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            wst_reg <= CPPS_W_IDLE;
          end
        end
        default: wst_reg <= CPPS_W_IDLE;
      endcase
    end
  end

  // Control register writes.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      cfg_idx_reg <= '0;
      col_sel_reg <= 2'h0;
      ctl_reg <= 4'h0;
      std_exp_reg <= 32'h0000_0000;
    end else if (wr_do) begin
      case (awaddr_reg)
        `CPPS_OFF_INDEX: cfg_idx_reg <= IW'(wdata_reg);
        `CPPS_OFF_COLOUR_SEL: begin
          // Only red, green and blue exist; other codes are dropped.
          if (wdata_reg[1:0] != 2'h3) begin
            col_sel_reg <= wdata_reg[1:0];
          end
        end
        `CPPS_OFF_CONTROL: ctl_reg <= wdata_reg[3:0];
        `CPPS_OFF_STD_EXPOSURE: begin
          // Standard setting is read-only while cycling owns it.
          if (!ctl_reg[`CPPS_CTL_CYCLE_EN]) begin
            std_exp_reg <= wdata_reg;
          end
        end
        default: ;
      endcase
    end
  end

  // Per-preset memory writes through the selected configuration index.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < PRESETS; i++) begin
        exp_mem[i] <= 32'h0000_0000;
        dly_mem[i] <= 32'h0000_0000;
        amp_mem[i] <= `CPPS_RST_GAIN;
        roi_mem[i] <= 32'h0000_0000;
        col_mem[i] <= {3{`CPPS_RST_GAIN}};
        mrg_mem[i] <= {`CPPS_RST_MERGE, `CPPS_RST_MERGE};
        pin_mem[i] <= 5'h00;
      end
    end else if (wr_do) begin
      case (awaddr_reg)
        `CPPS_OFF_EXPOSURE: exp_mem[ci] <= wdata_reg;
        `CPPS_OFF_LEAD_DELAY: dly_mem[ci] <= wdata_reg;
        `CPPS_OFF_AMP: amp_mem[ci] <= wdata_reg[15:0];
        `CPPS_OFF_ROI: begin
          roi_mem[ci] <= (roi_mem[ci] & ~wmask) | (wdata_reg & wmask);
        end
        `CPPS_OFF_COLOUR_GAIN: begin
          col_mem[ci][col_sel_reg*16 +: 16] <= wdata_reg[15:0];
        end
        `CPPS_OFF_MERGE: begin
          mrg_mem[ci] <= wdata_reg[15:0];
        end
        `CPPS_OFF_PIN: begin
          // Pin choice 3 is not a pin and is dropped.
          if (wdata_reg[1:0] != 2'h3) begin
            pin_mem[ci] <= wdata_reg[4:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Latched pin levels follow only the apply command.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      held_reg <= 3'h0;
    end else if (wr_do && awaddr_reg == `CPPS_OFF_COMMAND &&
                 wdata_reg[`CPPS_CMD_APPLY]) begin
      for (int k = 0; k < 3; k++) begin
        if (pin_mem[live_idx_reg][1:0] == 2'(k)) begin
          held_reg[k] <= pin_mem[live_idx_reg][`CPPS_PIN_LEVEL];
        end
      end
    end
  end

  // Switching presets only at a frame start keeps each frame uniform.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      live_idx_reg <= '0;
    end else if (FRAME_START_IN) begin
      live_idx_reg <= ACTIVE_INDEX_IN;
    end
  end

  // Registered outputs from the live preset; exposure uses the standard setting while cycling is off.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      EXPOSURE_DURATION_OUT <= 32'h0000_0000;
      EXPOSURE_LEAD_DELAY_OUT <= 32'h0000_0000;
      ANALOG_AMP_OUT <= 16'h0000;
      DIGITAL_AMP_OUT <= 16'h0000;
      ROI_ORIGIN_H_OUT <= 16'h0000;
      ROI_ORIGIN_V_OUT <= 16'h0000;
      COLOUR_GAIN_OUT <= 48'h0000_0000_0000;
      COLOUR_GAIN_VALID_OUT <= 1'b0;
      MERGE_H_OUT <= 8'h00;
      MERGE_V_OUT <= 8'h00;
    end else begin
      EXPOSURE_DURATION_OUT <= ctl_reg[`CPPS_CTL_CYCLE_EN] ?
        exp_mem[live_idx_reg] : std_exp_reg;
      EXPOSURE_LEAD_DELAY_OUT <= dly_mem[live_idx_reg];
      // Lower half of the range is analog, the rest digital.
      if (amp_mem[live_idx_reg][15]) begin
        ANALOG_AMP_OUT <= 16'h8000;
        DIGITAL_AMP_OUT <= amp_mem[live_idx_reg] - 16'h8000;
      end else begin
        ANALOG_AMP_OUT <= amp_mem[live_idx_reg];
        DIGITAL_AMP_OUT <= 16'h0000;
      end
      ROI_ORIGIN_H_OUT <= roi_mem[live_idx_reg][15:0];
      ROI_ORIGIN_V_OUT <= roi_mem[live_idx_reg][31:16];
      COLOUR_GAIN_OUT <= col_mem[live_idx_reg];
      COLOUR_GAIN_VALID_OUT <= !ctl_reg[`CPPS_CTL_AUTO_BAL] &&
                               !ctl_reg[`CPPS_CTL_AUTO_BRT];
      MERGE_H_OUT <= mrg_mem[live_idx_reg][7:0];
      MERGE_V_OUT <= mrg_mem[live_idx_reg][15:8];
    end
  end

  // Longest programmed exposure sets the frame period floor.
  always_comb begin
    max_w = 32'h0000_0000;
    for (int i = 0; i < PRESETS; i++) begin
      if (exp_mem[i] > max_w) begin
        max_w = exp_mem[i];
      end
    end
  end
  // The maximum leaves through a flip-flop, one cycle behind the memory.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      MAX_EXPOSURE_DURATION_OUT <= 32'h0000_0000;
    end else begin
      MAX_EXPOSURE_DURATION_OUT <= max_w;
    end
  end

  // Pin drivers, one per physical output.
  for (genvar g = 0; g < 3; g++) begin : g_pin
    always_comb begin
      if (pin_mem[live_idx_reg][1:0] == 2'(g)) begin
        pif[g].origin = pin_mem[live_idx_reg][3:2];
        // Latch off: written level applies at once.
        pif[g].level = ctl_reg[`CPPS_CTL_LATCH] ? held_reg[g] :
                       pin_mem[live_idx_reg][`CPPS_PIN_LEVEL];
      end else begin
        pif[g].origin = 2'h0;
        pif[g].level = 1'b0;
      end
    end
    cpps_pin_drv u_drv (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .exp_start_in(EXP_START_IN),
      .exp_active_in(EXP_ACTIVE_IN),
      .p(pif[g])
    );
    assign pin_w[g] = pif[g].pin;
  end

  // Pins leave through a flip-flop.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      OUTPUT_PIN_OUT <= 3'h0;
    end else begin
      OUTPUT_PIN_OUT <= pin_w;
    end
  end

  // Read channel: one cycle to answer, unmapped reads give SLVERR.
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT <= 1'b0;
      S_AXI_RDATA_OUT <= 32'h0000_0000;
      S_AXI_RRESP_OUT <= 2'h0;
    end else begin
      S_AXI_ARREADY_OUT <= 1'b0;
      if (S_AXI_RVALID_OUT) begin
        if (S_AXI_RREADY_IN) begin
          S_AXI_RVALID_OUT <= 1'b0;
        end
      end else if (S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT) begin
        S_AXI_ARREADY_OUT <= 1'b1;
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RRESP_OUT <= 2'h0;
        case (S_AXI_ARADDR_IN)
          `CPPS_OFF_INDEX: S_AXI_RDATA_OUT <= 32'(cfg_idx_reg);
          `CPPS_OFF_EXPOSURE: S_AXI_RDATA_OUT <= exp_mem[ci];
          `CPPS_OFF_LEAD_DELAY: S_AXI_RDATA_OUT <= dly_mem[ci];
          `CPPS_OFF_AMP: S_AXI_RDATA_OUT <= {16'h0000, amp_mem[ci]};
          `CPPS_OFF_ROI: S_AXI_RDATA_OUT <= roi_mem[ci];
          `CPPS_OFF_COLOUR_SEL: S_AXI_RDATA_OUT <= {30'h0, col_sel_reg};
          `CPPS_OFF_COLOUR_GAIN: begin
            S_AXI_RDATA_OUT <= {16'h0000,
                                col_mem[ci][col_sel_reg*16 +: 16]};
          end
          `CPPS_OFF_MERGE: S_AXI_RDATA_OUT <= {16'h0000, mrg_mem[ci]};
          `CPPS_OFF_PIN: begin
            S_AXI_RDATA_OUT <= {27'h0, pin_mem[ci]};
          end
          `CPPS_OFF_CONTROL: S_AXI_RDATA_OUT <= {28'h0, ctl_reg};
          `CPPS_OFF_COMMAND: S_AXI_RDATA_OUT <= 32'h0000_0000;
          `CPPS_OFF_STATUS: begin
            S_AXI_RDATA_OUT <= {25'h0, OUTPUT_PIN_OUT,
                                4'(live_idx_reg)};
          end
          `CPPS_OFF_STD_EXPOSURE: S_AXI_RDATA_OUT <= std_exp_reg;
          default: begin
            S_AXI_RDATA_OUT <= 32'h0000_0000;
            S_AXI_RRESP_OUT <= 2'h2;
          end
        endcase
      end
    end
  end
endmodule : cpps_store
`default_nettype wire
